// *** ptc_defines.vh ***
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH
// ==========================================================
// Register indices; byte address is four times the index
`define PTC_IDX_T3_CTL 16'hff39
`define PTC_IDX_T2_RELOAD 16'hff3a
`define PTC_IDX_T3_RELOAD 16'hff3b
`define PTC_ADDR_W 18
// ==========================================================
// Control field positions
`define PTC_BIT_SRC 0
`define PTC_BIT_PRESET 1
`define PTC_BIT_RUN 2
`define PTC_BIT_OUT 3
`define PTC_BIT_INV_OUT 4
// ==========================================================
// Reset values
`define PTC_CTL_RESET 1'b0
`define PTC_RELOAD_RESET 8'hff
`endif

// *** ptc_byte_reg.v ***
`timescale 1ns/1ps
`default_nettype none
module ptc_byte_reg #(
   parameter [7:0] RESET_VALUE = 8'h00
) (
   input wire clk_sys,
   input wire rstn,
   input wire ce,
   input wire wr_en,
   input wire [7:0] wr_data,
   output reg [7:0] value
);
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         value <= RESET_VALUE;
      end else if (ce && wr_en) begin
         value <= wr_data;
      end
   end
endmodule
`default_nettype wire

// *** ptc_timer_ctl.v ***
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.vh"
module ptc_timer_ctl (
   input wire clk_sys,
   input wire rstn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PTC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg t3_inv_clk_out_en,
   output reg t3_clk_out_en,
   output reg t3_run_ctl,
   output reg t3_preset_strobe,
   output reg t3_src_select,
   output wire [7:0] t3_reload,
   output wire [7:0] t2_reload
);
   // =======================================================
   // Address decode
   localparam [`PTC_ADDR_W-1:0] ADDR_T3_CTL = {`PTC_IDX_T3_CTL, 2'b00};
   localparam [`PTC_ADDR_W-1:0] ADDR_T2_RL = {`PTC_IDX_T2_RELOAD, 2'b00};
   localparam [`PTC_ADDR_W-1:0] ADDR_T3_RL = {`PTC_IDX_T3_RELOAD, 2'b00};

   wire hit_ctl;
   wire hit_t2;
   wire hit_t3;
   wire mapped;
   wire access;
   wire wr_fire;
   reg [31:0] next_prdata;

   assign hit_ctl = (paddr == ADDR_T3_CTL);
   assign hit_t2 = (paddr == ADDR_T2_RL);
   assign hit_t3 = (paddr == ADDR_T3_RL);
   assign mapped = hit_ctl | hit_t2 | hit_t3;
   // One wait state keeps read data straight from a flop
   assign access = psel & penable;
   assign wr_fire = access & pready & pwrite & mapped;

   // =======================================================
   // Read mux
   always @* begin
      next_prdata = 32'h00000000;
      if (hit_ctl) begin
         next_prdata[`PTC_BIT_INV_OUT] = t3_inv_clk_out_en;
         next_prdata[`PTC_BIT_OUT] = t3_clk_out_en;
         next_prdata[`PTC_BIT_RUN] = t3_run_ctl;
         next_prdata[`PTC_BIT_PRESET] = 1'b0;
         next_prdata[`PTC_BIT_SRC] = t3_src_select;
      end else if (hit_t2) begin
         next_prdata[7:0] = t2_reload;
      end else if (hit_t3) begin
         next_prdata[7:0] = t3_reload;
      end
   end

   // =======================================================
   // Bus handshake
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         if (access & ~pready & ~pwrite) begin
            prdata <= next_prdata;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // =======================================================
   // Control register
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         t3_inv_clk_out_en <= `PTC_CTL_RESET;
         t3_clk_out_en <= `PTC_CTL_RESET;
         t3_run_ctl <= `PTC_CTL_RESET;
         t3_preset_strobe <= 1'b0;
         t3_src_select <= `PTC_CTL_RESET;
      end else if (ce) begin
         t3_preset_strobe <= wr_fire & hit_ctl & pwdata[`PTC_BIT_PRESET];
         if (wr_fire && hit_ctl) begin
            t3_inv_clk_out_en <= pwdata[`PTC_BIT_INV_OUT];
            t3_clk_out_en <= pwdata[`PTC_BIT_OUT];
            t3_run_ctl <= pwdata[`PTC_BIT_RUN];
            t3_src_select <= pwdata[`PTC_BIT_SRC];
         end
      end
   end

   // =======================================================
   // Reload data
   // Third timer reload byte
   ptc_byte_reg #(
      .RESET_VALUE(`PTC_RELOAD_RESET)
   ) u_t3_reload (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .wr_en(wr_fire & hit_t3),
      .wr_data(pwdata[7:0]),
      .value(t3_reload)
   );

   ptc_byte_reg #(
      .RESET_VALUE(`PTC_RELOAD_RESET)
   ) u_t2_reload (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .wr_en(wr_fire & hit_t2),
      .wr_data(pwdata[7:0]),
      .value(t2_reload)
   );
endmodule
`default_nettype wire

// *** ptc_timer_ctl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptc_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic t3_inv_clk_out_en,
   input wire logic t3_clk_out_en,
   input wire logic t3_run_ctl,
   input wire logic t3_preset_strobe,
   input wire logic t3_src_select,
   input wire logic [7:0] t3_reload,
   input wire logic [7:0] t2_reload
);
   localparam logic [17:0] A_CTL = 18'h3fce4;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ==========
   // Completed writes and control register reads
   sequence s_wr(logic [17:0] a);
      // A frozen clock enable holds pready high without a write
      ce && pready && pwrite && paddr == a;
   endsequence
   chk_inv_write: assert property (s_wr(A_CTL) |=>
      t3_inv_clk_out_en == $past(pwdata[4])) else $error("inv bad");
   chk_out_write: assert property (s_wr(A_CTL) |=>
      t3_clk_out_en == $past(pwdata[3])) else $error("out bad");
   chk_run_write: assert property (s_wr(A_CTL) |=>
      t3_run_ctl == $past(pwdata[2])) else $error("run bad");
   chk_src_write: assert property (s_wr(A_CTL) |=>
      t3_src_select == $past(pwdata[0])) else $error("src bad");
   // Strobe lags the write edge by one cycle
   chk_preset_pulse: assert property (s_wr(A_CTL) ##0 pwdata[1] |=>
      t3_preset_strobe) else $error("preset bad");
   chk_read_zero: assert property (
      pready && !pwrite && paddr == A_CTL |-> prdata[31:5] == 0 && !prdata[1])
      else $error("ctl read bad");
   chk_t2_write: assert property (s_wr(18'h3fce8) |=>
      t2_reload == $past(pwdata[7:0])) else $error("t2 bad");
   chk_t3_write: assert property (s_wr(18'h3fcec) |=>
      t3_reload == $past(pwdata[7:0])) else $error("t3 bad");
endmodule
bind ptc_timer_ctl ptc_chk u_chk (.*);
`default_nettype wire

// *** prog_timer_ctl_reload_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module prog_timer_ctl_reload_test;
   logic clk_sys = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, st, er, t3_inv_clk_out_en, t3_clk_out_en;
   logic t3_run_ctl, t3_preset_strobe, t3_src_select;
   logic [7:0] t3_reload, t2_reload;
   int n_errors = 0, total_checks = 0, cyc = 0;
   // Row: address, write data, read back, {inv,out,run,src,t3,t2}
   logic [53:0] rows [5] = '{{18'h3fce4, 8'h1d, 8'h1d, 20'hfffff},
      {18'h3fce4, 8'hea, 8'h08, 20'h4ffff}, {18'h3fce8, 8'h5a, 8'h5a, 20'h4ff5a},
      {18'h3fcec, 8'ha5, 8'ha5, 20'h4a55a}, {18'h0, 8'h33, 8'h0, 20'h4a55a}};
   always #2 clk_sys = ~clk_sys;
   ptc_timer_ctl u_ptc_timer_ctl (.*);
   function logic [31:0] outs();
      return {t3_inv_clk_out_en, t3_clk_out_en, t3_run_ctl, t3_src_select,
         t3_reload, t2_reload};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========
   // Bus cycle; one idle cycle follows so strobe can be seen
   task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      #1 st = t3_preset_strobe;
      @(posedge clk_sys);
   endtask
   task do_reset;
      rstn <= 0;
      repeat (10) @(posedge clk_sys);
      chk(outs(), 32'h0ffff);
      chk({pready, t3_preset_strobe}, 32'h0);
      rstn <= 1;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_errors++;
         end_of_test;
      end
   end
   initial begin
      do_reset;
      foreach (rows[i]) begin
         apb(1, rows[i][53:36], rows[i][35:28]);
         chk(st, rows[i][53:36] == 18'h3fce4 && rows[i][29]);
         chk(outs(), rows[i][19:0]);
         apb(0, rows[i][53:36], 0);
         chk(rd, rows[i][27:20]);
         chk(er, i == 4);
      end
      // Clock enable low at setup stretches the transfer
      fork
         apb(1, 18'h3fce4, 32'h04);
         begin
            ce <= 0;
            repeat (3) @(posedge clk_sys);
            ce <= 1;
         end
      join
      chk(outs(), 32'h2a55a);
      // Reset in mid-run must clear a written control word
      apb(1, 18'h3fce4, 32'h1d);
      do_reset;
      end_of_test;
   end
endmodule
`default_nettype wire
